// ---- core/ccp_params.svh ----
// Constants of the cam parameter download interpreter.
// Assumes inclusion by bare name from core/ files.
//
// Notes on behaviour
// - Send sync pattern until controller echoes it
// - After sync echo send all-zero first word
// - Top two bits command, low fourteen address
// - Echo first request word; controller awaits echo
// - Fifth request word: logic inputs, variant only
// - Singleturn process data from fifth word
// - Multiturn layout: position, speed, program, outputs
// - Lowest output of group at bit zero
// - Offset table code one at address zero
// - Fixed codes for each parameter table type
// - Reference code only through simplified gateway
// - Offset entries: type, length, start address
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH

// ============================================================
// Protocol words and fields
`define CCP_SYNC_WORD      16'hc000
`define CCP_DONE_WORD      16'h0000
`define CCP_CMD_WRITE      2'h2
`define CCP_CMD_MSB        15
`define CCP_CMD_LSB        14
`define CCP_ADDR_MSB       13
`define CCP_STEP_BYTES     14'h0006
`define CCP_LAST_IDX       2'h2
`define CCP_FIRST_IDX      2'h0

// ============================================================
// Table type codes
`define CCP_OFFSET_CODE    16'h0001
`define CCP_ST_CAM_CODE    16'h0003
`define CCP_IDLE_CODE      16'h0004
`define CCP_CONFIG_CODE    16'h0005
`define CCP_MT_CAM_CODE    16'h0007
`define CCP_DIR_CAM_CODE   16'h0008
`define CCP_REF_CODE       16'h000a
`define CCP_AT_CAM_CODE    16'h000b
`define CCP_LOGIC_CODE     16'h000c

// ============================================================
// Table storage and response layout
`define CCP_WIDX_W         13
`define CCP_TABLE_WORDS    8192
`define CCP_RESP_WORDS     13
`define CCP_ZERO_ADDR      14'h0000
`define CCP_ZERO_WORD      16'h0000

`endif

// ---- core/ccp_pkg.sv ----
// Types shared by the cam parameter download interpreter.
// Assumes ccp_params.svh is reachable on the include path.
`include "ccp_params.svh"

package ccp_pkg;

    // Protocol phase, Gray coded along sync -> idle -> write
    typedef enum logic [1:0]
    {
        CCP_SYNC  = 2'h0,
        CCP_IDLE  = 2'h1,
        CCP_WRITE = 2'h3
    } ccp_phase_type;

    // Response words, word 0 first
    typedef logic [`CCP_RESP_WORDS-1:0][15:0] ccp_resp_type;

    // Whole state of the interpreter
    typedef struct packed
    {
        ccp_phase_type          phase;      // Protocol phase
        logic [1:0]             idx;        // Data word being stored
        logic [15:0]            req0;       // Request first word held
        logic [2:0][15:0]       data;       // Three data words held
        logic [15:0]            off_len;    // Declared offset table bytes
        logic [15:0]            logic_in;   // Logic input word
        logic                   reject;     // Last write was refused
        ccp_resp_type           resp;       // Response image
    } ccp_state_type;

    // Read port state of the table memory
    typedef struct packed
    {
        logic [15:0]            rd_data;    // Registered read word
    } ccp_ram_state_type;

endpackage

// ---- core/ccp_table_ram.sv ----
// Parameter table memory: one write port, one registered read port.
// Assumes one clock; the array holds no reset.
`timescale 1ns/1ns
`default_nettype none
`include "ccp_params.svh"

module ccp_table_ram
(
    input  wire logic                   clk_in,
    input  wire logic                   resetn_in,
    input  wire logic                   we_in,
    input  wire logic [`CCP_WIDX_W-1:0] waddr_in,
    input  wire logic [15:0]            wdata_in,
    input  wire logic [`CCP_WIDX_W-1:0] raddr_in,
    output logic      [15:0]            rdata_out
);
    import ccp_pkg::*;

    // ============================================================
    // Storage
    logic [15:0]       mem [`CCP_TABLE_WORDS];  // Table words
    ccp_ram_state_type st_reg;                  // Read register
    ccp_ram_state_type st_next;                 // Its next value

    // Read data follows address by one clock
    always_comb
    begin
        st_next.rd_data = mem[raddr_in];
    end

    // Array kept out of reset so it maps onto block memory
    always_ff @(posedge clk_in)
    begin
        if (we_in)
        begin
            mem[waddr_in] <= wdata_in;
        end
        if (!resetn_in)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rdata_out = st_reg.rd_data;

endmodule
`default_nettype wire

// ---- core/ccp_device.sv ----
// Cam control side of the cyclic fieldbus parameter download.
// Assumes one bus cycle per cycle_in pulse with request words stable then.
`timescale 1ns/1ns
`default_nettype none
`include "ccp_params.svh"

module ccp_device
(
    input  wire logic                   clk_in,
    input  wire logic                   resetn_in,
    input  wire logic                   cycle_in,
    input  wire logic [15:0]            req_w0_in,
    input  wire logic [15:0]            req_w1_in,
    input  wire logic [15:0]            req_w2_in,
    input  wire logic [15:0]            req_w3_in,
    input  wire logic [15:0]            req_w4_in,
    input  wire logic                   logic_variant_in,
    input  wire logic                   multiturn_in,
    input  wire logic                   gateway_simple_in,
    input  wire logic [31:0]            position_in,
    input  wire logic [15:0]            speed_in,
    input  wire logic [63:0]            outputs_in,
    input  wire logic [7:0]             active_program_number_in,
    input  wire logic [7:0]             error_number_in,
    input  wire logic [`CCP_WIDX_W-1:0] table_raddr_in,
    output logic      [15:0]            table_rdata_out,
    output ccp_pkg::ccp_resp_type       resp_out,
    output logic                        synced_out,
    output logic                        reject_out,
    output logic      [15:0]            logic_inputs_out
);
    import ccp_pkg::*;

    // ============================================================
    // Helpers

    // Table type codes the device accepts in the offset table
    function automatic logic code_ok(input logic [15:0] code, input logic gw);
        case (code)
            `CCP_ST_CAM_CODE, `CCP_IDLE_CODE, `CCP_CONFIG_CODE,
            `CCP_MT_CAM_CODE, `CCP_DIR_CAM_CODE, `CCP_AT_CAM_CODE,
            `CCP_LOGIC_CODE: code_ok = 1'b1;
            `CCP_REF_CODE:   code_ok = gw;
            default:         code_ok = 1'b0;
        endcase
    endfunction

    // Byte pointer of a request word to table word index
    function automatic logic [`CCP_WIDX_W-1:0] word_idx(input logic [15:0] w, input logic [1:0] k);
        word_idx = w[`CCP_ADDR_MSB:1] + `CCP_WIDX_W'(k);
    endfunction

    // ============================================================
    // State and request decode
    ccp_state_type   st_reg;      // Registered state
    ccp_state_type   st_next;     // Next state
    logic [1:0]      cmd;         // Request command field
    logic [13:0]     addr;        // Request byte pointer
    logic            take;        // Write request seen while idle
    logic            aligned;     // Pointer on a six byte step
    logic            type_ok;     // Offset entry content acceptable
    logic            accept;      // Write request will be stored
    logic            ram_we;      // Store one data word

    assign cmd     = req_w0_in[`CCP_CMD_MSB:`CCP_CMD_LSB];
    assign addr    = req_w0_in[`CCP_ADDR_MSB:0];
    assign take    = cycle_in && (st_reg.phase == CCP_IDLE) && (cmd == `CCP_CMD_WRITE);
    assign aligned = ((addr % `CCP_STEP_BYTES) == `CCP_ZERO_ADDR);

    // Offset entries are whole requests: type, length, address
    always_comb
    begin
        if (addr == `CCP_ZERO_ADDR)
        begin
            // Offset table declares itself first, at zero
            type_ok = (req_w1_in == `CCP_OFFSET_CODE)
                   && (req_w3_in == `CCP_ZERO_WORD);
        end
        else if ({2'h0, addr} < st_reg.off_len)
        begin
            type_ok = code_ok(req_w1_in, gateway_simple_in);
        end
        else
        begin
            type_ok = 1'b1;                                  // Plain table data
        end
    end

    assign accept = take && aligned && type_ok;
    assign ram_we = (st_reg.phase == CCP_WRITE);

    // ============================================================
    // Next state
    always_comb
    begin
        st_next = st_reg;
        case (st_reg.phase)
            CCP_SYNC:
            begin
                // Offer sync pattern until it comes back
                st_next.resp[0] = `CCP_SYNC_WORD;
                if (cycle_in && req_w0_in == `CCP_SYNC_WORD)
                begin
                    st_next.resp[0] = `CCP_DONE_WORD;
                    st_next.phase   = CCP_IDLE;
                end
            end
            CCP_IDLE:
            begin
                if (accept)
                begin
                    st_next.req0   = req_w0_in;
                    st_next.data   = {req_w3_in, req_w2_in, req_w1_in};
                    st_next.idx    = `CCP_FIRST_IDX;
                    st_next.reject = 1'b0;
                    st_next.phase  = CCP_WRITE;
                    if (addr == `CCP_ZERO_ADDR)
                    begin
                        st_next.off_len = req_w2_in;
                    end
                end
                else if (take)
                begin
                    // Refused: no echo, so the controller keeps waiting
                    st_next.reject = 1'b1;
                end
            end
            CCP_WRITE:
            begin
                // Echo only once all three words are stored
                st_next.idx = st_reg.idx + 2'h1;
                if (st_reg.idx == `CCP_LAST_IDX)
                begin
                    st_next.resp[0] = st_reg.req0;
                    st_next.phase   = CCP_IDLE;
                end
            end
            default:
            begin
                st_next.phase = CCP_SYNC;
            end
        endcase

        // Process data refresh every bus cycle; logic word too, on the logic variant only
        if (cycle_in)
        begin
            if (logic_variant_in)
            begin
                st_next.logic_in = req_w4_in;
            end
            st_next.resp[1] = `CCP_ZERO_WORD;
            st_next.resp[2] = `CCP_ZERO_WORD;
            st_next.resp[3] = `CCP_ZERO_WORD;
            if (multiturn_in)
            begin
                st_next.resp[4]  = position_in[31:16];
                st_next.resp[5]  = position_in[15:0];
                st_next.resp[6]  = speed_in;
                st_next.resp[7]  = {active_program_number_in, error_number_in};
                // Earlier byte is high byte; output 1 on bit 8
                st_next.resp[8]  = {outputs_in[7:0],   outputs_in[15:8]};
                st_next.resp[9]  = {outputs_in[23:16], outputs_in[31:24]};
                st_next.resp[10] = {outputs_in[39:32], outputs_in[47:40]};
                st_next.resp[11] = {outputs_in[55:48], outputs_in[63:56]};
                st_next.resp[12] = `CCP_ZERO_WORD;           // Reserved bytes
            end
            else
            begin
                st_next.resp[4]  = position_in[15:0];
                st_next.resp[5]  = speed_in;
                st_next.resp[6]  = outputs_in[15:0];
                st_next.resp[7]  = {active_program_number_in, error_number_in};
                st_next.resp[8]  = `CCP_ZERO_WORD;
                st_next.resp[9]  = `CCP_ZERO_WORD;
                st_next.resp[10] = `CCP_ZERO_WORD;
                st_next.resp[11] = `CCP_ZERO_WORD;
                st_next.resp[12] = `CCP_ZERO_WORD;
            end
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            st_reg         <= '0;
            st_reg.phase   <= CCP_SYNC;
            st_reg.resp[0] <= `CCP_SYNC_WORD;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ============================================================
    // Table memory
    ccp_table_ram u_table
    (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .we_in     (ram_we),
        .waddr_in  (word_idx(st_reg.req0, st_reg.idx)),
        .wdata_in  (st_reg.data[st_reg.idx]),
        .raddr_in  (table_raddr_in),
        .rdata_out (table_rdata_out)
    );

    assign resp_out         = st_reg.resp;
    assign synced_out       = (st_reg.phase != CCP_SYNC);
    assign reject_out       = st_reg.reject;
    assign logic_inputs_out = st_reg.logic_in;

    // ============================================================
    // Assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    property p_sync_word;
        st_reg.phase == CCP_SYNC |-> resp_out[0] == `CCP_SYNC_WORD;
    endproperty
    a_sync_word: assert property (p_sync_word) else $error("sync pattern missing");

    property p_sync_exit;
        st_reg.phase == CCP_SYNC && cycle_in && req_w0_in == `CCP_SYNC_WORD
            |=> resp_out[0] == `CCP_DONE_WORD && synced_out;
    endproperty
    a_sync_exit: assert property (p_sync_exit) else $error("sync not completed");

    property p_cmd_ignore;
        st_reg.phase == CCP_IDLE && cycle_in && cmd != `CCP_CMD_WRITE |=> st_reg.phase == CCP_IDLE;
    endproperty
    a_cmd_ignore: assert property (p_cmd_ignore) else $error("non write command acted on");

    property p_echo;
        accept |=> ram_we [*3] ##1 resp_out[0] == $past(req_w0_in, 4);
    endproperty
    a_echo: assert property (p_echo) else $error("echo not after three stores");

    property p_store_first;
        accept |=> ram_we && u_table.wdata_in == $past(req_w1_in);
    endproperty
    a_store_first: assert property (p_store_first) else $error("first data word not stored");

    property p_logic_word;
        cycle_in && logic_variant_in |=> logic_inputs_out == $past(req_w4_in);
    endproperty
    a_logic_word: assert property (p_logic_word) else $error("logic word not taken");

    property p_st_layout;
        cycle_in && !multiturn_in |=> resp_out[7] == {$past(active_program_number_in), $past(error_number_in)}
            && resp_out[4] == $past(position_in[15:0]);
    endproperty
    a_st_layout: assert property (p_st_layout) else $error("singleturn layout wrong");

    property p_mt_layout;
        cycle_in && multiturn_in |=> resp_out[4] == $past(position_in[31:16])
            && resp_out[12] == `CCP_ZERO_WORD;
    endproperty
    a_mt_layout: assert property (p_mt_layout) else $error("multiturn layout wrong");

    property p_out_bits;
        cycle_in && multiturn_in |=> resp_out[8][8] == $past(outputs_in[0])
            && resp_out[8][7] == $past(outputs_in[15]);
    endproperty
    a_out_bits: assert property (p_out_bits) else $error("output bit order wrong");

    property p_offset_first;
        take && addr == `CCP_ZERO_ADDR && req_w1_in != `CCP_OFFSET_CODE |=> reject_out && st_reg.phase == CCP_IDLE;
    endproperty
    a_offset_first: assert property (p_offset_first) else $error("bad offset header accepted");

    property p_ref_gate;
        take && aligned && addr != `CCP_ZERO_ADDR && {2'h0, addr} < st_reg.off_len
            && req_w1_in == `CCP_REF_CODE && !gateway_simple_in |=> reject_out;
    endproperty
    a_ref_gate: assert property (p_ref_gate) else $error("reference code accepted");

    c_sync: cover property (st_reg.phase == CCP_SYNC ##1 st_reg.phase == CCP_IDLE);
    c_write: cover property (accept ##4 resp_out[0][`CCP_CMD_MSB]);
    c_reject: cover property (take && !accept);

endmodule
`default_nettype wire

// ---- verif/ccp_plc_model.sv ----
// Behavioural controller that syncs with the interpreter and copies a small parameter table.
// Assumes the bench gates it with run_in and reads resp_out[0] into resp0_in.
`timescale 1ns/1ns
`default_nettype none

module ccp_plc_model
(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        run_in,
    input  wire logic [3:0]  slow_in,
    input  wire logic [15:0] resp0_in,
    output logic             cycle_out,
    output logic [15:0]      req_w0_out,
    output logic [15:0]      req_w1_out,
    output logic [15:0]      req_w2_out,
    output logic [15:0]      req_w3_out,
    output logic             idle_out,
    output logic             fault_out,
    output logic [7:0]       wraps_out
);
    // ============================================================
    // Table image: offset entry, cam entry, one cam record
    localparam int TABLE_BYTES = 18;
    logic [15:0] tbl [0:8];   // Word image, read by the bench as reference
    logic [13:0] ptr;         // Byte pointer of the next request

    // One request cycle; lines then carry a pattern, never a stale copy
    task automatic send(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2, input logic [15:0] w3);
        cycle_out = 1'b1;
        {req_w0_out, req_w1_out, req_w2_out, req_w3_out} = {w0, w1, w2, w3};
        @(negedge clk_in);
        cycle_out = 1'b0;
        {req_w0_out, req_w1_out, req_w2_out, req_w3_out} = ~{w0, w1, w2, w3};
    endtask

    // Bounded wait for a given first response word
    task automatic await_word(input logic [15:0] w);
        int n;
        n = 0;
        while (resp0_in !== w && n < 40)
        begin
            @(negedge clk_in);
            n++;
        end
        if (n == 40)
            fault_out = 1'b1;
    endtask

    // ============================================================
    // Main loop: sync once, then copy the table round and round
    initial
    begin
        tbl = '{16'h0001, 16'h000c, 16'h0000, 16'h0003, 16'h0006, 16'h000c,
                16'h0102, 16'h0304, 16'h0506};
        {cycle_out, idle_out, fault_out, wraps_out} = {1'b0, 1'b1, 1'b0, 8'h00};
        {req_w0_out, req_w1_out, req_w2_out, req_w3_out} = 64'h0;
        ptr = 14'h0000;
        forever
        begin
            @(negedge clk_in);
            if (run_in && resetn_in)
            begin
                idle_out = 1'b0;
                await_word(16'hc000);
                send(16'hc000, 16'h0000, 16'h0000, 16'h0000);
                await_word(16'h0000);
                ptr = 14'h0000;
                while (run_in)
                begin
                    send({2'h2, ptr}, tbl[ptr >> 1], tbl[(ptr >> 1) + 1], tbl[(ptr >> 1) + 2]);
                    await_word({2'h2, ptr});
                    repeat (slow_in) @(negedge clk_in);
                    ptr = ptr + 14'h0006;
                    if (ptr >= TABLE_BYTES)
                    begin
                        ptr = 14'h0000;
                        wraps_out = wraps_out + 8'h01;
                    end
                end
                idle_out = 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ---- verif/ccp_device_test.sv ----
// Self-checking bench of the cam parameter download interpreter.
// Assumes the design files under core/ and the controller model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "ccp_params.svh"

module ccp_device_test;
    import ccp_pkg::*;

    // ============================================================
    // Stimulus, outputs and bookkeeping
    logic clk_in, resetn_in, own, b_cycle, run, lv, mt, gw, p_cycle, p_idle, p_fault, synced, reject;
    logic [15:0] b_w0, b_w1, b_w2, b_w3, b_w4, p_w0, p_w1, p_w2, p_w3, speed, rdata, logic_out;
    logic [31:0] position;
    logic [63:0] outputs;
    logic [7:0] prog, err, wraps;
    logic [3:0] slow;
    logic [`CCP_WIDX_W-1:0] raddr;
    ccp_resp_type resp;
    int bad_count, total_checks;

    ccp_plc_model plc (.clk_in(clk_in), .resetn_in(resetn_in), .run_in(run), .slow_in(slow), .resp0_in(resp[0]),
        .cycle_out(p_cycle), .req_w0_out(p_w0), .req_w1_out(p_w1), .req_w2_out(p_w2), .req_w3_out(p_w3),
        .idle_out(p_idle), .fault_out(p_fault), .wraps_out(wraps));

    // Bench owns the request lines except while the model copies
    ccp_device dut (.clk_in(clk_in), .resetn_in(resetn_in), .cycle_in(own ? b_cycle : p_cycle),
        .req_w0_in(own ? b_w0 : p_w0), .req_w1_in(own ? b_w1 : p_w1), .req_w2_in(own ? b_w2 : p_w2),
        .req_w3_in(own ? b_w3 : p_w3), .req_w4_in(b_w4), .logic_variant_in(lv), .multiturn_in(mt),
        .gateway_simple_in(gw), .position_in(position), .speed_in(speed), .outputs_in(outputs),
        .active_program_number_in(prog), .error_number_in(err), .table_raddr_in(raddr),
        .table_rdata_out(rdata), .resp_out(resp), .synced_out(synced), .reject_out(reject),
        .logic_inputs_out(logic_out));

    // ============================================================
    // Shared helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One request; kind 0 echoed, 1 refused, 2 ignored
    task automatic bwrite(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2,
                          input logic [15:0] w3, input int kind);
        logic [15:0] prev0;
        logic prevr;
        prev0 = resp[0];
        prevr = reject;
        b_cycle = 1'b1;
        {b_w0, b_w1, b_w2, b_w3} = {w0, w1, w2, w3};
        @(negedge clk_in);
        b_cycle = 1'b0;
        {b_w0, b_w1, b_w2, b_w3} = ~{w0, w1, w2, w3};
        repeat (5) @(negedge clk_in);
        chk(resp[0], (kind == 0) ? w0 : prev0);
        chk({15'h0000, reject}, (kind == 2) ? {15'h0000, prevr} : ((kind == 1) ? 16'h0001 : 16'h0000));
    endtask

    // Table word at a given index, one edge of read latency
    task automatic rd_chk(input logic [`CCP_WIDX_W-1:0] idx, input logic [15:0] exp);
        raddr = idx;
        @(negedge clk_in);
        chk(rdata, exp);
    endtask

    // ============================================================
    // Scenarios
    task automatic t_sync;
        chk(resp[0], 16'hc000);
        chk({15'h0000, synced}, 16'h0000);
        bwrite(16'h8000, 16'h0001, 16'h000c, 16'h0000, 2);
        chk({15'h0000, synced}, 16'h0000);
    endtask

    // Model syncs, then copies the table twice with a slow answer
    task automatic t_download;
        int n;
        own = 1'b0;
        run = 1'b1;
        n = 0;
        while (wraps < 8'h02 && n < 3000)
        begin
            @(negedge clk_in);
            n++;
        end
        run = 1'b0;
        while (!p_idle && n < 3100)
        begin
            @(negedge clk_in);
            n++;
        end
        // Judge the wait by its goal, not by the shared counter
        if (wraps < 8'h02 || !p_idle)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, wraps, 8'h02);
            conclude;
        end
        own = 1'b1;
        chk({15'h0000, p_fault}, 16'h0000);
        chk({15'h0000, synced}, 16'h0001);
        chk({15'h0000, reject}, 16'h0000);
        for (int i = 0; i < 9; i++)
            rd_chk(i[`CCP_WIDX_W-1:0], plc.tbl[i]);
    endtask

    // Refusals, every table code, ignored commands
    task automatic t_refuse;
        logic [15:0] codes [0:6];
        logic [15:0] cmds [0:2];
        codes = '{16'h0003, 16'h0004, 16'h0005, 16'h0007, 16'h0008, 16'h000b, 16'h000c};
        cmds = '{16'h0006, 16'h4006, 16'hc006};
        bwrite(16'h8004, 16'h0003, 16'h0006, 16'h000c, 1);
        bwrite(16'h8000, 16'h0003, 16'h000c, 16'h0000, 1);
        bwrite(16'h8000, 16'h0001, 16'h000c, 16'h0006, 1);
        bwrite(16'h8006, 16'h0002, 16'h0006, 16'h000c, 1);
        gw = 1'b0;
        bwrite(16'h8006, 16'h000a, 16'h0006, 16'h000c, 1);
        gw = 1'b1;
        bwrite(16'h8006, 16'h000a, 16'h0006, 16'h000c, 0);
        // Plain data write between codes, so every echo differs from the last
        for (int i = 0; i < 7; i++)
        begin
            bwrite(16'h800c, codes[i], 16'h0000, 16'h0000, 0);
            bwrite(16'h8006, codes[i], 16'h0006, 16'h000c, 0);
            rd_chk(13'h0003, codes[i]);
        end
        rd_chk(13'h0003, 16'h000c);
        bwrite(16'h8005, 16'h0003, 16'h0006, 16'h000c, 1);
        for (int i = 0; i < 3; i++)
            bwrite(cmds[i], 16'h0003, 16'h0006, 16'h000c, 2);
    endtask

    // Process data in one layout; logic word taken only on the variant
    task automatic t_process(input logic multi);
        logic [15:0] e [0:12];
        {mt, lv} = {multi, !multi};
        {position, speed, outputs, prog, err} = {32'h1234_5678, 16'habcd, 64'h0123_4567_89ab_cdef, 8'h05, 8'h3c};
        b_w4 = multi ? 16'h5aa5 : 16'ha55a;
        b_cycle = 1'b1;
        b_w0 = 16'h0000;
        @(negedge clk_in);
        b_cycle = 1'b0;
        foreach (e[i])
            e[i] = 16'h0000;
        if (!multi)
            {e[4], e[5], e[6], e[7]} = {position[15:0], speed, outputs[15:0], prog, err};
        else
        begin
            {e[4], e[5], e[6], e[7]} = {position, speed, prog, err};
            for (int k = 0; k < 4; k++)
                e[8 + k] = {outputs[16 * k +: 8], outputs[16 * k + 8 +: 8]};
        end
        for (int k = 1; k < 13; k++)
            chk(resp[k], e[k]);
        chk(logic_out, 16'ha55a);
        // Let an edge pass with the strobe low before the next pulse
        @(negedge clk_in);
    endtask

    // ============================================================
    // Clock and main sequence
    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    initial
    begin
        {resetn_in, own, b_cycle, run, lv, mt, gw, slow, raddr} = '0;
        own = 1'b1;
        slow = 4'h3;
        {b_w0, b_w1, b_w2, b_w3, b_w4, speed, position, outputs, prog, err} = '0;
        bad_count = 0;
        total_checks = 0;
        repeat (12) @(negedge clk_in);
        resetn_in = 1'b1;
        t_sync;
        t_download;
        t_refuse;
        t_process(1'b0);
        t_process(1'b1);
        conclude;
    end
endmodule

`default_nettype wire
